//--- ltis_cmp_if.sv
// carrier between the status logic and one limit comparator
// assumes both ends sit in the same clock domain
`timescale 1ns/1ps
`default_nettype none

interface ltis_cmp_if #(
    parameter int RES_W = 10,
    parameter int LIM_W = 8
);
    logic [RES_W-1:0] result;
    logic [LIM_W-1:0] upperLimit;
    logic [LIM_W-1:0] lowerLimit;
    logic signedMode;
    logic aboveUpper;
    logic atOrBelowLower;

    modport cmp (
        input result,
        input upperLimit,
        input lowerLimit,
        input signedMode,
        output aboveUpper,
        output atOrBelowLower
    );

    modport user (
        output result,
        output upperLimit,
        output lowerLimit,
        output signedMode,
        input aboveUpper,
        input atOrBelowLower
    );
endinterface

`default_nettype wire

//--- ltis_host_model.sv
// host side model issuing register reads
// assumes one read strobe per access, answer one cycle later
`timescale 1ns/1ps
`default_nettype none

module ltis_host_model (
    input wire logic sys_clk,
    output logic regRead,
    output logic [7:0] regAddr,
    input wire logic regRdValid,
    input wire logic [7:0] regRdData
);
    initial begin
        regRead = 1'b0;
        regAddr = 8'h00;
    end

    // one read, answer taken in the cycle it stands, then released
    task automatic doRead(input logic [7:0] a, output logic [7:0] d, output logic ok);
        @(negedge sys_clk);
        regRead = 1'b1;
        regAddr = a;
        @(negedge sys_clk);
        ok = regRdValid;
        d = regRdData;
        regRead = 1'b0;
        regAddr = ~a;
    endtask
endmodule

`default_nettype wire

//--- ltis_limit_cmp.sv
// one channel's high and low limit comparison
// assumes result and limits are stable, combinational output
`timescale 1ns/1ps
`default_nettype none

module ltis_limit_cmp #(
    parameter int RES_W = 10,
    parameter int LIM_W = 8
) (
    ltis_cmp_if.cmp bus
);

    // ****************************************
    // comparison on the upper result bits
    // ****************************************
    logic [LIM_W-1:0] resultTop;

    assign resultTop = bus.result[RES_W-1 -: LIM_W];

    always_comb begin
        if (bus.signedMode) begin
            bus.aboveUpper = $signed(resultTop) > $signed(bus.upperLimit);
            bus.atOrBelowLower = $signed(resultTop) <= $signed(bus.lowerLimit);
        end else begin
            bus.aboveUpper = resultTop > bus.upperLimit;
            bus.atOrBelowLower = resultTop <= bus.lowerLimit;
        end
    end

endmodule

`default_nettype wire

//--- ltis_pkg.sv
// constants for the limit status block: offsets, fields, channels
// assumes one 40 MHz clock domain and a serial engine outside
`default_nettype none

package ltis_pkg;

    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [7:0] OFS_STATUS_FIRST = 8'h00;
    localparam logic [7:0] OFS_STATUS_SECOND = 8'h01;
    localparam logic [7:0] OFS_CORE_LOW_BITS = 8'h03;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [7:0] STATUS_FIRST_RST = 8'h00;
    localparam logic [7:0] STATUS_SECOND_RST = 8'h00;
    localparam logic [9:0] RESULT_RST = 10'h000;
    localparam logic [7:0] READ_DATA_RST = 8'h00;
    localparam logic [7:0] EXT_UPPER_LIMIT_DEFAULT = 8'hFF;
    localparam logic [7:0] EXT_LOWER_LIMIT_DEFAULT = 8'h00;

    // ****************************************
    // first status register fields
    // ****************************************
    localparam int S1_CORE_HIGH = 0;
    localparam int S1_CORE_LOW = 1;
    localparam int S1_EXT_HIGH = 2;
    localparam int S1_EXT_LOW = 3;
    localparam int S1_EXT_FAULT = 4;
    localparam int S1_AIN_TWO = 5;
    localparam int S1_AIN_THREE = 6;
    localparam int S1_AIN_FOUR = 7;

    // ****************************************
    // second status register fields
    // ****************************************
    localparam int S2_AIN_FIVE = 0;
    localparam int S2_SUPPLY = 4;
    localparam int S2_USED_W = 5;

    // ****************************************
    // low-bits register fields
    // ****************************************
    localparam int LB_CORE_POS = 0;
    localparam int LB_SUPPLY_POS = 2;
    localparam int LB_FIELD_W = 2;

    // ****************************************
    // channel numbering
    // ****************************************
    localparam int NUM_CH = 10;
    localparam logic [3:0] CH_CORE = 4'h0;
    localparam logic [3:0] CH_EXT = 4'h1;
    localparam logic [3:0] CH_AIN_TWO = 4'h2;
    localparam logic [3:0] CH_AIN_FIVE = 4'h5;
    localparam logic [3:0] CH_SUPPLY = 4'h9;

endpackage

`default_nettype wire

//--- ltis_status_top.sv
// out-of-limit status flags, read-clear logic and interrupt pin
// assumes a serial engine outside giving read strobes and results
//
// Functional notes
// - first status bit 0 sets when core temperature exceeds its upper limit.
// - first status bit 1 sets when core temperature is at or below lower limit.
// - bit 2 meaning follows the external pin mode setting.
// - external mode: bit 2 sets when external temperature exceeds upper limit.
// - analog mode: bit 2 sets when input one crosses either limit.
// - external mode: bit 3 sets when external temperature is at or below its lower limit.
// - external mode: bit 4 sets on external sensor open or short fault, analog mode keeps it zero.
// - bits 5 to 7 flag analog inputs two to four, either limit.
// - second status bits 0 to 3 flag analog inputs five to eight.
// - second status bit 4 flags supply, bits 5 to 7 read zero.
// - reading a status register clears only flags whose condition is gone.
// - software reset clears flags whose condition is gone in both status registers, also zero at power-up.
// - any set flag drives the interrupt output active.
// - low-bits register holds core temperature bits one and zero.
// - low-bits register also holds supply result bits one and zero.
// - masked channels never raise their flag.
// - interrupt pin level follows the polarity setting, except that reset drives it low.
// - eight-bit limits compare against the top of ten-bit results.
`timescale 1ns/1ps
`default_nettype none

module ltis_status_top
    import ltis_pkg::*;
#(
    parameter int RES_W = 10,
    parameter int LIM_W = 8
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic resultStrobe,
    input wire logic [3:0] resultChannel,
    input wire logic [RES_W-1:0] resultData,
    input wire logic [NUM_CH-1:0][LIM_W-1:0] upperLimit,
    input wire logic [NUM_CH-1:0][LIM_W-1:0] lowerLimit,
    input wire logic [7:0] maskFirst,
    input wire logic [7:0] maskSecond,
    input wire logic extSensorMode,
    input wire logic extSensorFault,
    input wire logic intActiveHigh,
    input wire logic softReset,
    input wire logic regRead,
    input wire logic [7:0] regAddr,
    output logic [7:0] regRdData,
    output logic regRdValid,
    output logic intPin
);

    // ****************************************
    // parameter checks
    // ****************************************
    if (RES_W != 10) begin : g_res_check
        $error("result width must be 10");
    end
    if (LIM_W < 1 || LIM_W > RES_W) begin : g_lim_check
        $error("limit width must lie between 1 and result width");
    end

    // ****************************************
    // declarations
    // ****************************************
    logic [NUM_CH-1:0][RES_W-1:0] result_reg;
    logic [7:0] statusFirst_reg;
    logic [7:0] statusFirst_next;
    logic [7:0] statusSecond_reg;
    logic [7:0] statusSecond_next;
    logic [7:0] regRdData_reg;
    logic [7:0] regRdData_next;
    logic regRdValid_reg;
    logic intPin_reg;
    logic intPin_next;
    logic [NUM_CH-1:0] chAbove;
    logic [NUM_CH-1:0] chBelow;
    logic [NUM_CH-1:0] chOut;
    logic [7:0] condFirst;
    logic [7:0] condSecond;
    logic [7:0] eventFirst;
    logic [7:0] eventSecond;
    logic [7:0] lowBits;
    logic readFirst;
    logic readSecond;

    // ****************************************
    // address decode
    // ****************************************
    function automatic logic hitAddr(
        input logic rd,
        input logic [7:0] addr,
        input logic [7:0] ofs
    );
        hitAddr = rd && (addr == ofs);
    endfunction

    assign readFirst = hitAddr(regRead, regAddr, OFS_STATUS_FIRST);
    assign readSecond = hitAddr(regRead, regAddr, OFS_STATUS_SECOND);

    // ****************************************
    // result capture
    // ****************************************
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            result_reg <= {NUM_CH{RESULT_RST}};
        end else if (resultStrobe && (resultChannel < NUM_CH)) begin
            result_reg[resultChannel] <= resultData;
        end
    end

    // ****************************************
    // per-channel comparators
    // ****************************************
    for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
        ltis_cmp_if #(.RES_W(RES_W), .LIM_W(LIM_W)) cmpBus ();

        assign cmpBus.result = result_reg[g];
        assign cmpBus.upperLimit = upperLimit[g];
        assign cmpBus.lowerLimit = lowerLimit[g];
        if (g == CH_CORE) begin : g_core
            assign cmpBus.signedMode = 1'b1;
        end else if (g == CH_EXT) begin : g_ext
            assign cmpBus.signedMode = extSensorMode;
        end else begin : g_volt
            assign cmpBus.signedMode = 1'b0;
        end
        assign chAbove[g] = cmpBus.aboveUpper;
        assign chBelow[g] = cmpBus.atOrBelowLower;
        assign chOut[g] = cmpBus.aboveUpper | cmpBus.atOrBelowLower;

        ltis_limit_cmp #(.RES_W(RES_W), .LIM_W(LIM_W)) u_cmp (
            .bus(cmpBus)
        );
    end

    // ****************************************
    // first status conditions
    // ****************************************
    always_comb begin
        condFirst = 8'h00;
        condFirst[S1_CORE_HIGH] = chAbove[CH_CORE];
        condFirst[S1_CORE_LOW] = chBelow[CH_CORE];
        if (extSensorMode) begin
            condFirst[S1_EXT_HIGH] = chAbove[CH_EXT];
            condFirst[S1_EXT_LOW] = chBelow[CH_EXT];
            condFirst[S1_EXT_FAULT] = extSensorFault;
        end else begin
            condFirst[S1_EXT_HIGH] = chOut[CH_EXT];
        end
        condFirst[S1_AIN_FOUR:S1_AIN_TWO] = chOut[CH_AIN_TWO +: 3];
    end

    // ****************************************
    // second status conditions
    // ****************************************
    always_comb begin
        condSecond = 8'h00;
        condSecond[S2_AIN_FIVE +: 4] = chOut[CH_AIN_FIVE +: 4];
        condSecond[S2_SUPPLY] = chOut[CH_SUPPLY];
    end

    // ****************************************
    // mask gating
    // ****************************************
    assign eventFirst = condFirst & ~maskFirst;
    assign eventSecond = condSecond & ~maskSecond & 8'((1 << S2_USED_W) - 1);

    // ****************************************
    // sticky flag update
    // ****************************************
    always_comb begin
        if (softReset || readFirst) begin
            statusFirst_next = eventFirst;
        end else begin
            statusFirst_next = statusFirst_reg | eventFirst;
        end
    end

    always_comb begin
        if (softReset || readSecond) begin
            statusSecond_next = eventSecond;
        end else begin
            statusSecond_next = statusSecond_reg | eventSecond;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            statusFirst_reg <= STATUS_FIRST_RST;
        end else begin
            statusFirst_reg <= statusFirst_next;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            statusSecond_reg <= STATUS_SECOND_RST;
        end else begin
            statusSecond_reg <= statusSecond_next;
        end
    end

    // ****************************************
    // low-bits register view
    // ****************************************
    always_comb begin
        lowBits = 8'h00;
        lowBits[LB_CORE_POS +: LB_FIELD_W] = result_reg[CH_CORE][LB_FIELD_W-1:0];
        lowBits[LB_SUPPLY_POS +: LB_FIELD_W] = result_reg[CH_SUPPLY][LB_FIELD_W-1:0];
    end

    // ****************************************
    // read data
    // ****************************************
    always_comb begin
        unique case (regAddr)
            OFS_STATUS_FIRST: regRdData_next = statusFirst_reg;
            OFS_STATUS_SECOND: regRdData_next = statusSecond_reg;
            OFS_CORE_LOW_BITS: regRdData_next = lowBits;
            default: regRdData_next = READ_DATA_RST;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            regRdData_reg <= READ_DATA_RST;
        end else if (regRead) begin
            regRdData_reg <= regRdData_next;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            regRdValid_reg <= 1'b0;
        end else begin
            regRdValid_reg <= regRead;
        end
    end

    // ****************************************
    // interrupt pin
    // ****************************************
    always_comb begin
        if (|statusFirst_reg || |statusSecond_reg) begin
            intPin_next = intActiveHigh;
        end else begin
            intPin_next = !intActiveHigh;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            intPin_reg <= 1'b0;
        end else begin
            intPin_reg <= intPin_next;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign regRdData = regRdData_reg;
    assign regRdValid = regRdValid_reg;
    assign intPin = intPin_reg;

endmodule

`default_nettype wire

//--- ltis_status_top_assertions.sv
// port checker for the limit status block
// assumes it is bound onto ltis_status_top
`timescale 1ns/1ps
`default_nettype none

module ltis_status_top_assertions
    import ltis_pkg::*;
#(
    parameter int RES_W = 10,
    parameter int LIM_W = 8
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic resultStrobe,
    input wire logic [3:0] resultChannel,
    input wire logic [RES_W-1:0] resultData,
    input wire logic [NUM_CH-1:0][LIM_W-1:0] upperLimit,
    input wire logic [7:0] maskFirst,
    input wire logic [7:0] maskSecond,
    input wire logic intActiveHigh,
    input wire logic regRead,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regRdData,
    input wire logic regRdValid,
    input wire logic intPin
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    logic [1:0] coreLowReg;
    logic [1:0] supLowReg;

    // last low bits written for the core and supply channels
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            coreLowReg <= 2'h0;
            supLowReg <= 2'h0;
        end else if (resultStrobe && resultChannel == CH_CORE) begin
            coreLowReg <= resultData[1:0];
        end else if (resultStrobe && resultChannel == CH_SUPPLY) begin
            supLowReg <= resultData[1:0];
        end
    end

    sequence s_rdTaken;
        regRead;
    endsequence
    sequence s_coreHigh;
        resultStrobe && resultChannel == CH_CORE && !maskFirst[S1_CORE_HIGH]
            && $signed(resultData[9:2]) > $signed(upperLimit[CH_CORE]);
    endsequence
    sequence s_supplyHigh;
        resultStrobe && resultChannel == CH_SUPPLY && !maskSecond[S2_SUPPLY]
            && resultData[9:2] > upperLimit[CH_SUPPLY];
    endsequence

    property p_rdAnswer;
        s_rdTaken |-> ##1 regRdValid;
    endproperty
    property p_rdQuiet;
        !regRead |=> !regRdValid;
    endproperty
    property p_rdHold;
        !regRead |=> $stable(regRdData);
    endproperty
    property p_unmapped;
        regRead && (regAddr == 8'h02 || regAddr > OFS_CORE_LOW_BITS) |=> regRdData == 8'h00;
    endproperty
    property p_lowBits;
        regRead && regAddr == OFS_CORE_LOW_BITS |=> regRdData == {4'h0, $past(supLowReg), $past(coreLowReg)};
    endproperty
    property p_st2Rsvd;
        regRead && regAddr == OFS_STATUS_SECOND |=> regRdData[7:5] == 3'h0;
    endproperty
    property p_coreInt;
        s_coreHigh |-> ##[1:4] (intPin == intActiveHigh);
    endproperty
    property p_supplyInt;
        s_supplyHigh |-> ##[1:4] (intPin == intActiveHigh);
    endproperty

    a_rdAnswer: assert property (p_rdAnswer) else $error("no read answer");
    a_rdQuiet: assert property (p_rdQuiet) else $error("stray read answer");
    a_rdHold: assert property (p_rdHold) else $error("read data moved");
    a_unmapped: assert property (p_unmapped) else $error("unmapped not zero");
    a_lowBits: assert property (p_lowBits) else $error("low bits wrong");
    a_st2Rsvd: assert property (p_st2Rsvd) else $error("reserved bits set");
    a_coreInt: assert property (p_coreInt) else $error("core high no pin");
    a_supplyInt: assert property (p_supplyInt) else $error("supply high no pin");
endmodule

bind ltis_status_top ltis_status_top_assertions #(.RES_W(RES_W), .LIM_W(LIM_W)) u_chk (
    .sys_clk(sys_clk), .rst_n(rst_n), .resultStrobe(resultStrobe), .resultChannel(resultChannel),
    .resultData(resultData), .upperLimit(upperLimit), .maskFirst(maskFirst), .maskSecond(maskSecond),
    .intActiveHigh(intActiveHigh), .regRead(regRead), .regAddr(regAddr), .regRdData(regRdData),
    .regRdValid(regRdValid), .intPin(intPin)
);

`default_nettype wire

//--- ltis_status_top_tb.sv
// self-checking bench for the limit status block
// assumes the checker binds itself onto the design
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin nCompared++; if ((a) !== (b)) begin errCount++; $display("MISMATCH %0t got %h want %h", $time, a, b); end end

module ltis_status_top_tb
    import ltis_pkg::*;
;
    localparam logic [9:0] MID = 10'h100;
    localparam logic [9:0] HIV = 10'h1F0;
    localparam logic [9:0] LOV = 10'h040;
    logic sys_clk, rst_n, resultStrobe, extSensorMode, extSensorFault, intActiveHigh, softReset;
    logic regRead, regRdValid, intPin;
    logic [3:0] resultChannel;
    logic [9:0] resultData;
    logic [NUM_CH-1:0][7:0] upperLimit, lowerLimit;
    logic [7:0] maskFirst, maskSecond, regAddr, regRdData;
    int errCount, nCompared, cycles;

    ltis_status_top dut (.sys_clk(sys_clk), .rst_n(rst_n), .resultStrobe(resultStrobe),
        .resultChannel(resultChannel), .resultData(resultData), .upperLimit(upperLimit),
        .lowerLimit(lowerLimit), .maskFirst(maskFirst), .maskSecond(maskSecond),
        .extSensorMode(extSensorMode), .extSensorFault(extSensorFault), .intActiveHigh(intActiveHigh),
        .softReset(softReset), .regRead(regRead), .regAddr(regAddr), .regRdData(regRdData),
        .regRdValid(regRdValid), .intPin(intPin));
    ltis_host_model host (.sys_clk(sys_clk), .regRead(regRead), .regAddr(regAddr),
        .regRdValid(regRdValid), .regRdData(regRdData));

    always #12.5 sys_clk = ~sys_clk;

    task automatic wrapUp();
        $display("compared %0d mismatches %0d", nCompared, errCount);
        if (errCount == 0 && nCompared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            errCount++;
            wrapUp();
        end
    end

    task automatic idle(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    task automatic setRes(input logic [3:0] ch, input logic [9:0] v);
        @(negedge sys_clk);
        resultStrobe = 1'b1;
        resultChannel = ch;
        resultData = v;
        @(negedge sys_clk);
        resultStrobe = 1'b0;
        resultChannel = 4'hF;
    endtask

    task automatic chkRd(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        logic ok;
        host.doRead(a, d, ok);
        `CHK(ok, 1'b1)
        `CHK(d, e)
    endtask

    // raise, withdraw, then sticky read and clearing read
    task automatic chkPass(input logic [3:0] ch, input logic [9:0] v, input logic [15:0] e);
        setRes(ch, v);
        setRes(ch, MID);
        idle(3);
        `CHK(intPin, intActiveHigh)
        chkRd(OFS_STATUS_FIRST, e[7:0]);
        chkRd(OFS_STATUS_SECOND, e[15:8]);
        chkRd(OFS_STATUS_FIRST, 8'h00);
        chkRd(OFS_STATUS_SECOND, 8'h00);
        idle(2);
        `CHK(intPin, ~intActiveHigh)
    endtask

    function automatic logic [15:0] bitOf(input int ch, input logic lo);
        if (ch == 0) begin
            bitOf = lo ? 16'h0002 : 16'h0001;
        end else if (ch == 1) begin
            bitOf = lo ? 16'h0008 : 16'h0004;
        end else begin
            bitOf = 16'h0001 << (ch + 3);
        end
    endfunction

    task automatic sResetValues();
        chkRd(OFS_STATUS_FIRST, STATUS_FIRST_RST);
        chkRd(OFS_STATUS_SECOND, STATUS_SECOND_RST);
        chkRd(8'h02, 8'h00);
        `CHK(intPin, 1'b0)
    endtask

    task automatic sLowBits();
        for (int ch = 0; ch < NUM_CH; ch++) setRes(4'(ch), MID);
        setRes(CH_CORE, 10'h101);
        setRes(CH_SUPPLY, 10'h102);
        chkRd(OFS_CORE_LOW_BITS, 8'h09);
        maskFirst = 8'h00;
        maskSecond = 8'h00;
        idle(3);
        chkRd(OFS_STATUS_FIRST, 8'h00);
    endtask

    task automatic sLimits();
        for (int lo = 0; lo < 2; lo++)
            for (int ch = 0; ch < NUM_CH; ch++)
                chkPass(4'(ch), lo[0] ? LOV : HIV, bitOf(ch, lo[0]));
    endtask

    task automatic sAnalog();
        extSensorMode = 1'b0;
        intActiveHigh = 1'b0;
        chkPass(CH_EXT, HIV, 16'h0004);
        chkPass(CH_EXT, LOV, 16'h0004);
        extSensorMode = 1'b1;
        intActiveHigh = 1'b1;
    endtask

    task automatic sFault();
        extSensorFault = 1'b1;
        idle(3);
        chkRd(OFS_STATUS_FIRST, 8'h10);
        chkRd(OFS_STATUS_FIRST, 8'h10);
        extSensorFault = 1'b0;
        idle(2);
        chkRd(OFS_STATUS_FIRST, 8'h10);
        chkRd(OFS_STATUS_FIRST, 8'h00);
    endtask

    task automatic sMaskEdge();
        maskFirst = 8'h01;
        setRes(CH_CORE, HIV);
        setRes(CH_AIN_TWO, 10'h183);
        idle(3);
        chkRd(OFS_STATUS_FIRST, 8'h00);
        setRes(CH_CORE, MID);
        maskFirst = 8'h00;
        chkPass(CH_AIN_TWO, 10'h083, 16'h0020);
    endtask

    task automatic sSoftReset();
        setRes(CH_AIN_FIVE, HIV);
        setRes(CH_AIN_FIVE, MID);
        idle(2);
        `CHK(intPin, 1'b1)
        softReset = 1'b1;
        idle(1);
        softReset = 1'b0;
        idle(2);
        `CHK(intPin, 1'b0)
        chkRd(OFS_STATUS_SECOND, 8'h00);
    endtask

    initial begin
        sys_clk = 1'b0;
        rst_n = 1'b0;
        resultStrobe = 1'b0;
        resultChannel = 4'hF;
        resultData = MID;
        upperLimit = {NUM_CH{8'h60}};
        lowerLimit = {NUM_CH{8'h20}};
        maskFirst = 8'hFF;
        maskSecond = 8'hFF;
        extSensorMode = 1'b1;
        extSensorFault = 1'b0;
        intActiveHigh = 1'b1;
        softReset = 1'b0;
        errCount = 0;
        nCompared = 0;
        cycles = 0;
        idle(16);
        rst_n = 1'b1;
        idle(1);
        sResetValues();
        sLowBits();
        sLimits();
        sAnalog();
        sFault();
        sMaskEdge();
        sSoftReset();
        wrapUp();
    end
endmodule

`default_nettype wire
